/* verilog/slts_regs.svh */
// slts_regs.svh: offsets, fields, codes and timing of the squib loop test block
// assumes a 100 MHz sys_clk and a register port fed by the spi frame decoder
// How it works
// [RQ1] code 1001 in the system test request selects deploy time replay, diag only
// [RQ2] replay request written outside the diag state is rejected, register unchanged
// [RQ3] while the request holds the replay code, deploy config writes are ignored
// [RQ4] controller writes another request code before rewriting deploy config
// [RQ5] timing pin pulses once per channel, 0 to 3, for its deploy time
// [RQ6] pulse rising edges are 8 ms apart, start to start
// [RQ7] unconfigured channel gives an 8 us pulse
// [RQ8] invalid time/current pair reverts to the default pair, replay shows it
// [RQ9] request bit 15 selects high level mode, steps run without more writes
// [RQ10] high level mode inserts the preparatory step the test needs
// [RQ11] config bit 10 picks short or long step time, writable only in init
// [RQ12] request bits 7:5 select the test, 100 unused
// [RQ13] request bit 4 selects side: 0 return pin, 1 feed pin
// [RQ14] request bits 1:0 select channel 0 to 3
// [RQ15] prelim fault status bit reads 0 unless high level mode
// [RQ16] fault in leakage or fet prelim step sets prelim fault and aborts
// [RQ17] a reference check request tests one side only
// [RQ18] status bit 19 high level mode, 18 running, echo test and channel
// [RQ19] status bit 7 loop short, 6 ground short, 5 supply short, 4 side
// [RQ20] low side reference check reports working reference as supply short
// [RQ21] pin stays low after channel 3 until a new replay request
`ifndef SLTS_REGS_SVH
`define SLTS_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SLTS_OFF_SYSCFG 8'h01
`define SLTS_OFF_DCFG0 8'h06
`define SLTS_OFF_SYSTEST 8'h36
`define SLTS_OFF_LSTAT 8'h37
`define SLTS_OFF_LREQ 8'h38
// ----------------------------------------
// fields and codes
// ----------------------------------------
`define SLTS_NUM_CH 4
`define SLTS_STCODE_MSB 3
`define SLTS_CODE_REPLAY 4'h9
`define SLTS_SYSCFG_LONG 10
`define SLTS_SYSCFG_RST 16'h0000
`define SLTS_LREQ_HL 15
`define SLTS_LREQ_TEST_MSB 7
`define SLTS_LREQ_TEST_LSB 5
`define SLTS_LREQ_SIDE 4
`define SLTS_LREQ_CH_LSB 0
`define SLTS_TEST_NONE 3'h0
`define SLTS_TEST_REF 3'h1
`define SLTS_TEST_LEAK 3'h2
`define SLTS_TEST_UNUSED 3'h4
`define SLTS_TEST_FET 3'h7
`define SLTS_ST_HL 19
`define SLTS_ST_RUN 18
`define SLTS_ST_PF 16
`define SLTS_ST_TEST_LSB 8
`define SLTS_ST_LOOP 7
`define SLTS_ST_STG 6
`define SLTS_ST_STB 5
`define SLTS_ST_SIDE 4
`define SLTS_ST_CH_LSB 0
`define SLTS_DCFG_TIME_MSB 1
`define SLTS_DCFG_TIME_LSB 0
`define SLTS_DCFG_CUR 2
`define SLTS_DTIME_05 2'h1
`define SLTS_DTIME_07 2'h2
`define SLTS_DTIME_20 2'h3
`define SLTS_DCFG_DEFAULT 3'h1
`define SLTS_DCFG_RST 16'h0000
// ----------------------------------------
// timing, microseconds and derived cycles
// ----------------------------------------
`define SLTS_CLK_MHZ 100
`define SLTS_T_NOCFG_US 8
`define SLTS_T_DEPL05_US 500
`define SLTS_T_DEPL07_US 700
`define SLTS_T_DEPL20_US 2000
`define SLTS_T_SPACING_US 8000
`define SLTS_T_STEP_SHORT_US 20
`define SLTS_T_STEP_LONG_US 40
`define SLTS_CYC(us) ((us) * `SLTS_CLK_MHZ)
`endif

/* verilog/slts_pkg.sv */
// slts_pkg.sv: types of the squib loop test block
// assumes the constants of slts_regs.svh
`default_nettype none
package slts_pkg;
   typedef enum logic [2:0] {ST_INIT, ST_DIAG, ST_SAFING, ST_SCRAP, ST_ARMING} slts_opstate_e;
   typedef enum logic [1:0] {SQ_IDLE, SQ_PREP, SQ_RUN} slts_seq_e;
   typedef logic [19:0] slts_cnt_t;
   typedef logic [15:0] slts_word_t;
   typedef logic [19:0] slts_stat_t;
   typedef struct packed {
      logic hl;
      logic [2:0] test;
      logic side;
      logic [1:0] ch;
   } slts_loopreq_s;
   typedef struct packed {
      logic loopShort;
      logic short_to_ground_flag;
      logic stb;
      logic fault;
   } slts_result_s;
endpackage
`default_nettype wire

/* verilog/slts_replay.sv */
// slts_replay.sv: replays the four deploy times as pulses on the timing pin
// assumes start is a one-cycle strobe from the register set; stop is a strobe or a held level
`timescale 1ns/1ns
`default_nettype none
`include "slts_regs.svh"
module slts_replay
   import slts_pkg::*;
#(
   parameter slts_cnt_t SPACING_CYC = slts_cnt_t'(`SLTS_CYC(`SLTS_T_SPACING_US))
)
(
   // clock, reset and enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // control
   input wire logic start,
   input wire logic stop,
   input wire slts_cnt_t dur [`SLTS_NUM_CH],
   // pin side
   output logic pinOut,
   output logic active
);
   logic active_ff, nxt_active;
   logic pin_ff, nxt_pin;
   logic [1:0] ch_ff, nxt_ch;
   slts_cnt_t cnt_ff, nxt_cnt;
   logic slotEnd;
   // ----------------------------------------
   // slot sequencing
   // ----------------------------------------
   assign slotEnd = active_ff && (cnt_ff == SPACING_CYC - slts_cnt_t'(1)); // see RQ6
   assign nxt_active = start ? 1'b1
                     : (stop || (slotEnd && ch_ff == 2'h3)) ? 1'b0 : active_ff; // see RQ21
   assign nxt_cnt = (start || !active_ff || slotEnd) ? '0 : slts_cnt_t'(cnt_ff + 20'h1);
   assign nxt_ch = start ? 2'h0 : slotEnd ? 2'(ch_ff + 2'h1) : ch_ff;
   assign nxt_pin = nxt_active && (nxt_cnt < dur[nxt_ch]); // see RQ5
   assign pinOut = pin_ff;
   assign active = active_ff;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         active_ff <= 1'b0;
         pin_ff <= 1'b0;
         ch_ff <= 2'h0;
         cnt_ff <= '0;
      end
      else if (clkEn)
      begin
         active_ff <= nxt_active;
         pin_ff <= nxt_pin;
         ch_ff <= nxt_ch;
         cnt_ff <= nxt_cnt;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_idle_low;
      !active_ff |-> !pin_ff;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("pin high while idle"); // see RQ21
   property p_rise_slot;
      $rose(pin_ff) |-> cnt_ff == '0;
   endproperty
   a_rise_slot: assert property (p_rise_slot) else $error("pulse off slot start"); // see RQ6
   property p_width;
      pin_ff |-> cnt_ff < dur[ch_ff];
   endproperty
   a_width: assert property (p_width) else $error("pulse longer than deploy time"); // see RQ5
endmodule
`default_nettype wire

/* verilog/slts_hl_seq.sv */
// slts_hl_seq.sv: high level loop test sequencer, prelim and run steps
// assumes the analog front end holds result levels valid at step end
`timescale 1ns/1ns
`default_nettype none
`include "slts_regs.svh"
module slts_hl_seq
   import slts_pkg::*;
(
   // clock, reset and enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // request
   input wire logic start,
   input wire logic clear,
   input wire slts_loopreq_s req,
   input wire logic longSteps,
   // analog front end
   input wire slts_result_s meas,
   output logic stepActive,
   output logic prelimStep,
   // results
   output logic running,
   output slts_result_s flags
);
   localparam logic [11:0] SHORT_CYC = 12'(`SLTS_CYC(`SLTS_T_STEP_SHORT_US));
   localparam logic [11:0] LONG_CYC = 12'(`SLTS_CYC(`SLTS_T_STEP_LONG_US));
   slts_seq_e state_ff, nxt_state;
   logic [11:0] cnt_ff, nxt_cnt;
   slts_result_s flags_ff, nxt_flags, setVec;
   logic stepEnd, needPrep, runnable, prepFail, runEnd;
   // ----------------------------------------
   // step control
   // ----------------------------------------
   assign stepEnd = (state_ff != SQ_IDLE)
                  && (cnt_ff == (longSteps ? LONG_CYC : SHORT_CYC) - 12'h1); // see RQ11
   assign needPrep = (req.test == `SLTS_TEST_LEAK) || (req.test == `SLTS_TEST_FET); // see RQ10
   assign runnable = req.hl && (req.test != `SLTS_TEST_NONE)
                   && (req.test != `SLTS_TEST_UNUSED); // see RQ12
   assign prepFail = (state_ff == SQ_PREP) && stepEnd && meas.fault; // see RQ16
   assign runEnd = (state_ff == SQ_RUN) && stepEnd;
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         SQ_IDLE: nxt_state = SQ_IDLE;
         SQ_PREP: if (stepEnd) nxt_state = meas.fault ? SQ_IDLE : SQ_RUN; // see RQ16
         SQ_RUN: if (stepEnd) nxt_state = SQ_IDLE; // see RQ17
         default: nxt_state = SQ_IDLE;
      endcase
      if (start) nxt_state = !runnable ? SQ_IDLE : needPrep ? SQ_PREP : SQ_RUN; // see RQ9
   end
   assign nxt_cnt = (start || stepEnd || state_ff == SQ_IDLE) ? 12'h0 : 12'(cnt_ff + 12'h1);
   // ----------------------------------------
   // result flags, set wins over clear
   // ----------------------------------------
   assign setVec.loopShort = runEnd && meas.loopShort;
   assign setVec.short_to_ground_flag = runEnd && meas.short_to_ground_flag;
   assign setVec.stb = runEnd && meas.stb; // see RQ20
   assign setVec.fault = prepFail;
   assign nxt_flags = (clear ? slts_result_s'(4'h0) : flags_ff) | setVec;
   assign stepActive = state_ff != SQ_IDLE;
   assign prelimStep = state_ff == SQ_PREP;
   assign running = stepActive;
   assign flags = flags_ff;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state_ff <= SQ_IDLE;
         cnt_ff <= 12'h0;
         flags_ff <= slts_result_s'(4'h0);
      end
      else if (clkEn)
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         flags_ff <= nxt_flags;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_run_done;
      clkEn && runEnd && !start;
   endsequence
   property p_prelim_abort;
      clkEn && prepFail && !start |=> flags_ff.fault && state_ff == SQ_IDLE;
   endproperty
   a_prelim_abort: assert property (p_prelim_abort) else $error("prelim fault lost"); // see RQ16
   property p_prep_first;
      clkEn && start && runnable && needPrep |=> state_ff == SQ_PREP;
   endproperty
   a_prep_first: assert property (p_prep_first) else $error("prep step skipped"); // see RQ10
   property p_one_side;
      s_run_done |=> !running;
   endproperty
   a_one_side: assert property (p_one_side) else $error("second run step"); // see RQ17
endmodule
`default_nettype wire

/* verilog/slts_top.sv */
// slts_top.sv: squib loop test control: register set, deploy config lock,
// deploy time replay on the timing pin and high level loop test status
// assumes one register access per cycle from the spi frame decoder and an
// analog front end that answers each measurement step with result levels
`timescale 1ns/1ns
`default_nettype none
`include "slts_regs.svh"
module slts_top
   import slts_pkg::*;
#(
   parameter slts_cnt_t DEPL05_CYC = slts_cnt_t'(`SLTS_CYC(`SLTS_T_DEPL05_US)),
   parameter slts_cnt_t DEPL07_CYC = slts_cnt_t'(`SLTS_CYC(`SLTS_T_DEPL07_US)),
   parameter slts_cnt_t DEPL20_CYC = slts_cnt_t'(`SLTS_CYC(`SLTS_T_DEPL20_US)),
   parameter slts_cnt_t SPACING_CYC = slts_cnt_t'(`SLTS_CYC(`SLTS_T_SPACING_US))
)
(
   // clock, reset and enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // register port
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire slts_word_t regWrData,
   input wire logic regRdEn,
   output logic [19:0] regRdData,
   // operating state of the device
   input wire slts_opstate_e opState,
   // analog measurement front end
   output slts_loopreq_s measReq,
   output logic measStepActive,
   output logic measPrelimStep,
   input wire slts_result_s measResult,
   // deployment side
   output logic [3:0][15:0] deployCfg,
   output logic timingReportPin
);
   localparam slts_cnt_t NOCFG_CYC = slts_cnt_t'(`SLTS_CYC(`SLTS_T_NOCFG_US));

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] off);
      hitAddr = addr == off;
   endfunction

   // duration of the replay pulse for one channel's config
   function automatic slts_cnt_t durOf(input slts_word_t cfg);
      case (cfg[`SLTS_DCFG_TIME_MSB:`SLTS_DCFG_TIME_LSB])
         `SLTS_DTIME_05: durOf = DEPL05_CYC;
         `SLTS_DTIME_07: durOf = DEPL07_CYC;
         `SLTS_DTIME_20: durOf = DEPL20_CYC;
         default: durOf = NOCFG_CYC;
      endcase
   endfunction

   // long pulse at high current is not allowed, fall back to default pair
   function automatic slts_word_t fixCfg(input slts_word_t w);
      fixCfg = w;
      if (w[`SLTS_DCFG_CUR] && w[`SLTS_DCFG_TIME_MSB:`SLTS_DCFG_TIME_LSB] == `SLTS_DTIME_20)
         fixCfg[`SLTS_DCFG_CUR:`SLTS_DCFG_TIME_LSB] = `SLTS_DCFG_DEFAULT;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [3:0] stCode_ff, nxt_stCode;
   slts_word_t sysCfg_ff, nxt_sysCfg;
   slts_loopreq_s loopReq_ff, nxt_loopReq, wrLoopReq;
   slts_word_t cfg_ff [`SLTS_NUM_CH];
   slts_word_t nxt_cfg [`SLTS_NUM_CH];
   slts_stat_t rdData_ff, nxt_rdData;
   slts_stat_t statusWord;
   slts_cnt_t chDur [`SLTS_NUM_CH];
   logic [`SLTS_NUM_CH-1:0] cfgWr;
   slts_result_s seqFlags;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire logic wrStrobe;
   wire logic isDiag;
   wire logic stWr;
   wire logic replayReq;
   wire logic stReject;
   wire logic stAccept;
   wire logic replayStart;
   wire logic replayStop;
   wire logic replayActive;
   wire logic cfgLock;
   wire logic sysCfgWr;
   wire logic loopWr;
   wire logic seqStart;
   wire logic flagClear;
   wire logic seqRunning;
   wire logic hlMode;

   assign wrStrobe = regWrEn && clkEn;
   assign isDiag = opState == ST_DIAG;
   assign stWr = wrStrobe && hitAddr(regAddr, `SLTS_OFF_SYSTEST);
   assign replayReq = stWr && (regWrData[`SLTS_STCODE_MSB:0] == `SLTS_CODE_REPLAY); // see RQ1
   assign stReject = replayReq && !isDiag; // see RQ2
   assign stAccept = stWr && !stReject;
   assign replayStart = stAccept && replayReq; // see RQ1
   // a new code ends the replay, so does leaving the diag state
   assign replayStop = (stAccept && !replayReq) || !isDiag;
   // lock stays after the replay ends, released only by a new code
   assign cfgLock = stCode_ff == `SLTS_CODE_REPLAY; // see RQ3
   assign sysCfgWr = wrStrobe && hitAddr(regAddr, `SLTS_OFF_SYSCFG) && (opState == ST_INIT); // see RQ11
   assign loopWr = wrStrobe && hitAddr(regAddr, `SLTS_OFF_LREQ) && (opState != ST_INIT);
   // any accepted request restarts; a low level one sends the sequencer idle
   assign seqStart = loopWr; // see RQ9
   assign flagClear = loopWr || stAccept;
   assign hlMode = loopReq_ff.hl;

   // ----------------------------------------
   // request register fields
   // ----------------------------------------
   assign wrLoopReq.hl = regWrData[`SLTS_LREQ_HL]; // see RQ9
   assign wrLoopReq.test = regWrData[`SLTS_LREQ_TEST_MSB:`SLTS_LREQ_TEST_LSB]; // see RQ12
   assign wrLoopReq.side = regWrData[`SLTS_LREQ_SIDE]; // see RQ13
   assign wrLoopReq.ch = regWrData[`SLTS_LREQ_CH_LSB +: 2]; // see RQ14

   assign nxt_stCode = stAccept ? regWrData[`SLTS_STCODE_MSB:0] : stCode_ff; // see RQ4
   assign nxt_sysCfg = sysCfgWr ? regWrData : sysCfg_ff;
   assign nxt_loopReq = loopWr ? wrLoopReq : loopReq_ff;

   // ----------------------------------------
   // deploy config per channel
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `SLTS_NUM_CH; g++)
      begin : g_ch
         assign cfgWr[g] = wrStrobe && !cfgLock
                         && hitAddr(regAddr, 8'(`SLTS_OFF_DCFG0 + g)); // see RQ3
         assign nxt_cfg[g] = cfgWr[g] ? fixCfg(regWrData) : cfg_ff[g]; // see RQ8
         assign chDur[g] = durOf(cfg_ff[g]); // see RQ7
         assign deployCfg[g] = cfg_ff[g];
      end
   endgenerate

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         stCode_ff <= 4'h0;
         sysCfg_ff <= `SLTS_SYSCFG_RST;
         loopReq_ff <= slts_loopreq_s'(7'h00);
         cfg_ff <= '{default: `SLTS_DCFG_RST};
         rdData_ff <= 20'h00000;
      end
      else if (clkEn)
      begin
         stCode_ff <= nxt_stCode;
         sysCfg_ff <= nxt_sysCfg;
         loopReq_ff <= nxt_loopReq;
         cfg_ff <= nxt_cfg;
         rdData_ff <= nxt_rdData;
      end
   end

   // ----------------------------------------
   // replay of deploy times
   // ----------------------------------------
   slts_replay #(
      .SPACING_CYC(SPACING_CYC)
   ) u_replay (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .start(replayStart),
      .stop(replayStop),
      .dur(chDur),
      .pinOut(timingReportPin),
      .active(replayActive)
   );

   // ----------------------------------------
   // high level sequencer
   // ----------------------------------------
   slts_hl_seq u_seq (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .start(seqStart),
      .clear(flagClear),
      .req(nxt_loopReq),
      .longSteps(sysCfg_ff[`SLTS_SYSCFG_LONG]),
      .meas(measResult),
      .stepActive(measStepActive),
      .prelimStep(measPrelimStep),
      .running(seqRunning),
      .flags(seqFlags)
   );
   assign measReq = loopReq_ff;

   // ----------------------------------------
   // status word and read port
   // ----------------------------------------
   always_comb
   begin
      statusWord = 20'h00000;
      statusWord[`SLTS_ST_HL] = hlMode; // see RQ18
      statusWord[`SLTS_ST_RUN] = seqRunning; // see RQ18
      statusWord[`SLTS_ST_PF] = hlMode && seqFlags.fault; // see RQ15
      statusWord[`SLTS_ST_TEST_LSB +: 3] = loopReq_ff.test; // see RQ18
      statusWord[`SLTS_ST_LOOP] = seqFlags.loopShort; // see RQ19
      statusWord[`SLTS_ST_STG] = seqFlags.short_to_ground_flag; // see RQ19
      statusWord[`SLTS_ST_STB] = seqFlags.stb; // see RQ19
      statusWord[`SLTS_ST_SIDE] = loopReq_ff.side; // see RQ19
      statusWord[`SLTS_ST_CH_LSB +: 2] = loopReq_ff.ch; // see RQ18
   end
   // only the status register reads back, the rest are write only
   assign nxt_rdData = !regRdEn ? rdData_ff
                     : hitAddr(regAddr, `SLTS_OFF_LSTAT) ? statusWord : 20'h00000;
   assign regRdData = rdData_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_cfg_lock;
      cfgLock && wrStrobe |=> deployCfg == $past(deployCfg);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("config changed while locked"); // see RQ3

   property p_reject;
      stReject |=> stCode_ff == $past(stCode_ff);
   endproperty
   a_reject: assert property (p_reject) else $error("replay taken outside diag"); // see RQ2

   property p_replay_go;
      replayStart |=> replayActive;
   endproperty
   a_replay_go: assert property (p_replay_go) else $error("replay did not start"); // see RQ1

   property p_revert;
      cfgWr[0] && regWrData[`SLTS_DCFG_CUR]
      && regWrData[`SLTS_DCFG_TIME_MSB:`SLTS_DCFG_TIME_LSB] == `SLTS_DTIME_20
      |=> cfg_ff[0][`SLTS_DCFG_CUR:`SLTS_DCFG_TIME_LSB] == `SLTS_DCFG_DEFAULT
          && chDur[0] == DEPL05_CYC;
   endproperty
   a_revert: assert property (p_revert) else $error("invalid pair kept"); // see RQ8

   property p_nocfg;
      cfg_ff[1][`SLTS_DCFG_TIME_MSB:`SLTS_DCFG_TIME_LSB] == 2'h0 |-> chDur[1] == NOCFG_CYC;
   endproperty
   a_nocfg: assert property (p_nocfg) else $error("unconfigured width wrong"); // see RQ7

   property p_init_only;
      wrStrobe && hitAddr(regAddr, `SLTS_OFF_SYSCFG) && opState != ST_INIT
      |=> sysCfg_ff == $past(sysCfg_ff);
   endproperty
   a_init_only: assert property (p_init_only) else $error("config written outside init"); // see RQ11

   property p_pf_zero;
      !hlMode |-> !statusWord[`SLTS_ST_PF];
   endproperty
   a_pf_zero: assert property (p_pf_zero) else $error("prelim fault outside hl mode"); // see RQ15

   property p_status_read;
      regRdEn && clkEn && hitAddr(regAddr, `SLTS_OFF_LSTAT)
      |=> regRdData[`SLTS_ST_RUN] == $past(seqRunning)
          && regRdData[`SLTS_ST_SIDE] == $past(loopReq_ff.side);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read mismatch"); // see RQ18
endmodule
`default_nettype wire

/* test/slts_mcu_model.sv */
// slts_mcu_model.sv: controller side of the register port
// assumes accesses start at the falling edge, one at a time
`timescale 1ns/1ns
`default_nettype none
module slts_mcu_model
   import slts_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // register port
   output logic regWrEn,
   output logic regRdEn,
   output logic [7:0] regAddr,
   output slts_word_t regWrData,
   input wire logic [19:0] regRdData
);
   initial
   begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
   end
   // released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input slts_word_t d);
      @(negedge sys_clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge sys_clk);
      regWrEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [19:0] d);
      @(negedge sys_clk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge sys_clk);
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdData;
   endtask
endmodule
`default_nettype wire

/* test/squib_loop_test_sequencer_tb_top.sv */
// squib_loop_test_sequencer_tb_top.sv: self-checking bench of slts_top
// assumes short replay counts and the register model in slts_mcu_model
`timescale 1ns/1ns
`default_nettype none
module squib_loop_test_sequencer_tb_top
   import slts_pkg::*;
;
   localparam int D05 = 50;
   localparam int D07 = 70;
   localparam int D20 = 200;
   localparam int SPC = 1000;
   typedef struct {logic [7:0] a; slts_word_t d; slts_word_t e;} slts_row_s;
   slts_row_s rows [4] = '{'{8'h06, 16'h0001, 16'h0001}, '{8'h07, 16'h0002, 16'h0002},
      '{8'h08, 16'h0003, 16'h0003}, '{8'h09, 16'h0007, 16'h0001}};
   int expW [4] = '{D05, D07, D20, D05};
   logic sys_clk, rst_b, clkEn, regWrEn, regRdEn, pin, stepAct, prelim;
   logic prevPin = 1'b0;
   logic [7:0] regAddr;
   slts_word_t regWrData;
   logic [19:0] regRdData, rdv;
   slts_opstate_e opState;
   slts_loopreq_s measReq;
   slts_result_s measResult;
   logic [3:0][15:0] deployCfg;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int hi = 0;
   int k;
   int rises[$];
   int widths[$];
   slts_top #(.DEPL05_CYC(slts_cnt_t'(D05)), .DEPL07_CYC(slts_cnt_t'(D07)),
      .DEPL20_CYC(slts_cnt_t'(D20)), .SPACING_CYC(slts_cnt_t'(SPC))) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .regWrEn(regWrEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .opState(opState), .measReq(measReq),
      .measStepActive(stepAct), .measPrelimStep(prelim), .measResult(measResult),
      .deployCfg(deployCfg), .timingReportPin(pin));
   slts_mcu_model mcu (.sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // pulse starts and widths on the timing pin
   always @(negedge sys_clk)
   begin
      cyc++;
      if (pin === 1'b1 && prevPin !== 1'b1)
      begin
         rises.push_back(cyc);
         hi = 0;
      end
      if (pin === 1'b1)
         hi++;
      if (pin !== 1'b1 && prevPin === 1'b1)
         widths.push_back(hi);
      prevPin = pin;
   end
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic replay(input int n);
      rises.delete();
      widths.delete();
      mcu.wr(8'h36, 16'h0009);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wait_step;
      k = 0;
      while (stepAct !== 1'b0 && k < 9000)
      begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 9000)
      begin
         fail_count++;
         give_verdict();
      end
   endtask
   initial
   begin
      rst_b = 1'b0;
      clkEn = 1'b1;
      opState = ST_INIT;
      measResult = 4'h0;
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
      mcu.wr(8'h01, 16'h0000);
      mcu.wr(8'h36, 16'h0009);
      foreach (rows[i])
      begin
         mcu.wr(rows[i].a, rows[i].d);
         check("deploy config", deployCfg[i], rows[i].e);
      end
      check("pin outside replay", pin, 1'b0);
      opState = ST_DIAG;
      replay(4300);
      check("pulse count", rises.size(), 4);
      foreach (expW[i])
         check("pulse width", widths[i], expW[i]);
      for (int i = 1; i < 4; i++)
         check("pulse spacing", rises[i] - rises[i-1], SPC);
      mcu.wr(8'h06, 16'h0002);
      check("locked config", deployCfg[0], 16'h0001);
      mcu.wr(8'h36, 16'h0000);
      mcu.wr(8'h06, 16'h0000);
      check("unlocked config", deployCfg[0], 16'h0000);
      replay(1100);
      check("unconfigured width", widths[0], 800);
      mcu.wr(8'h36, 16'h0000);
      check("pin after stop", pin, 1'b0);
      measResult = 4'h2;
      mcu.wr(8'h38, 16'h8022);
      check("request echo", measReq, 7'h4a);
      check("step active", {stepAct, prelim}, 2'b10);
      wait_step();
      mcu.rd(8'h37, rdv);
      check("low side reference", rdv, 20'h80122);
      measResult = 4'h1;
      mcu.wr(8'h38, 16'h8051);
      check("prelim step", prelim, 1'b1);
      wait_step();
      check("abort early", k < 2100, 1'b1);
      mcu.rd(8'h37, rdv);
      check("prelim fault", rdv, 20'h90211);
      mcu.wr(8'h38, 16'h0020);
      mcu.rd(8'h37, rdv);
      check("fault in low level", {rdv[19], rdv[16]}, 2'b00);
      mcu.rd(8'h3f, rdv);
      check("unmapped read", rdv, 20'h00000);
      clkEn = 1'b0;
      mcu.wr(8'h38, 16'h8022);
      check("frozen request", measReq, 7'h08);
      clkEn = 1'b1;
      rst_b = 1'b0;
      @(negedge sys_clk);
      rst_b = 1'b1;
      check("reset state", {measReq, deployCfg[1]}, 23'h0);
      opState = ST_INIT;
      mcu.wr(8'h01, 16'h0400);
      opState = ST_DIAG;
      mcu.wr(8'h01, 16'h0000);
      measResult = 4'h0;
      mcu.wr(8'h38, 16'h8022);
      wait_step();
      check("long step", k > 3900, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
